// File: common/tmg_pkg.sv
// constants, types and field layout of the transmit modulator data gate
// Summary of operation
// - no ramp align: fall stops data, idle fill
// - no ramp align: gap counts from symbol end
// - ramp align on: gap delay from strobe rise
// - burst start delay, eighth symbols, from rise
// - idle fill bit before burst start delay ends
// - serial mode: start delay only when clock output
// - idle fill bit whenever data input inactive
package tmg_pkg;
    // ========================================
    // register bus
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;
    localparam logic [9:0] REG_DELAYS_IDX = 10'h036; // word index of the delay register
    localparam logic [9:0] REG_CONTROL_IDX = 10'h037;
    localparam logic [9:0] REG_STATUS_IDX = 10'h038;
    localparam logic [11:0] REG_DELAYS_ADDR = {REG_DELAYS_IDX, 2'b00};
    localparam logic [11:0] REG_CONTROL_ADDR = {REG_CONTROL_IDX, 2'b00};
    localparam logic [11:0] REG_STATUS_ADDR = {REG_STATUS_IDX, 2'b00};
    // ========================================
    // field layout
    localparam int DELAY_W = 9;
    localparam int START_DELAY_LSB = 0;
    localparam int RESUME_DELAY_LSB = 9;
    localparam int DELAYS_W = 18;
    localparam int CONTROL_W = 6;
    localparam int STATUS_W = 10;
    localparam logic [17:0] DELAYS_RESET = 18'h0_0000;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    // ========================================
    // timing
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int SYMBOL_PERIOD_NS = 64;
    localparam int EIGHTHS_PER_SYMBOL = 8;
    localparam int EIGHTH_RAW = SYMBOL_PERIOD_NS / EIGHTHS_PER_SYMBOL / CLOCK_PERIOD_NS;
    localparam int EIGHTH_CYCLES = (EIGHTH_RAW < 1) ? 1 : EIGHTH_RAW;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 1;
    // ========================================
    // types
    typedef struct packed {
        logic [8:0] inter_slot_resume_delay;
        logic [8:0] burst_start_delay;
    } tmg_delays_s;
    typedef struct packed {
        logic idle_fill_bit;
        logic ramp_align_mode;
        logic bitclk_is_output;
        logic serial_mode;
        logic gprs_mode;
        logic enable;
    } tmg_control_s;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_START = 6'b00_0010,
        ST_FLOW = 6'b00_0100,
        ST_DRAIN = 6'b00_1000,
        ST_HOLD = 6'b01_0000,
        ST_GAP = 6'b10_0000
    } tmg_state_e;
endpackage

// File: logic/tmg_gate.sv
// transmit data fifo and modulator data gate with apb registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// ========================================
// fifo
module tmg_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    // handshakes and next fill level
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign next_count = count + CW'(push) - CW'(pop);
    assign out_data = mem[rd_ptr];

    // storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers, level and honest flags
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != CW'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end
endmodule

// ========================================
// gate top
module tmg_gate
    import tmg_pkg::*;
#(
    parameter int EIGHTH_DIV = EIGHTH_CYCLES
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_ADDR_W-1:0] PADDR,
    input wire logic [APB_DATA_W-1:0] PWDATA,
    output logic [APB_DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // link pins from the baseband
    input wire logic TX_SLOT_STROBE,
    input wire logic MOD_BIT_CLOCK,
    // transmit data stream
    input wire logic TX_DATA_VALID,
    input wire logic TX_DATA,
    output logic TX_DATA_READY,
    // modulator input
    output logic MOD_DATA,
    output logic MOD_DATA_ACTIVE
);
    tmg_delays_s dly;
    tmg_control_s ctrl;
    tmg_state_e state;
    logic [DELAY_W-1:0] cnt;
    logic [DELAY_W-1:0] start_load;
    logic [2:0] strobe_sync;
    logic [2:0] bclk_sync;
    logic strobe_rise;
    logic strobe_fall;
    logic sym_tick;
    logic tick8;
    logic [7:0] div_cnt;
    logic fifo_valid;
    logic fifo_data;
    logic fifo_ready;
    logic pop;
    logic apb_setup;
    logic apb_write;
    logic addr_hit;

    // ========================================
    // apb slave: data prepared in setup, answered in the access cycle
    assign apb_setup = PSEL && !PENABLE;
    assign apb_write = PSEL && PENABLE && PREADY && PWRITE;
    assign addr_hit = (PADDR == REG_DELAYS_ADDR) || (PADDR == REG_CONTROL_ADDR)
        || (PADDR == REG_STATUS_ADDR);

    // ready and error flags for the access cycle
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= apb_setup;
            PSLVERR <= apb_setup && !addr_hit;
        end
    end

    // read data captured during the setup cycle
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            PRDATA <= '0;
        end else if (apb_setup && !PWRITE) begin
            unique case (PADDR)
                REG_DELAYS_ADDR: PRDATA <= {{(APB_DATA_W - DELAYS_W){1'b0}}, dly};
                REG_CONTROL_ADDR: PRDATA <= {{(APB_DATA_W - CONTROL_W){1'b0}}, ctrl};
                REG_STATUS_ADDR: PRDATA <= {{(APB_DATA_W - STATUS_W){1'b0}},
                    strobe_sync[1], MOD_DATA_ACTIVE, TX_DATA_READY, fifo_valid, state};
                default: PRDATA <= '0;
            endcase
        end
    end

    // delay and control registers
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            dly <= DELAYS_RESET;
            ctrl <= CONTROL_RESET;
        end else if (apb_write && !PSLVERR) begin
            if (PADDR == REG_DELAYS_ADDR) begin
                dly <= PWDATA[DELAYS_W-1:0];
            end
            if (PADDR == REG_CONTROL_ADDR) begin
                ctrl <= PWDATA[CONTROL_W-1:0];
            end
        end
    end

    // ========================================
    // link pins: two flip-flops, then a third for edges
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            strobe_sync <= '0;
            bclk_sync <= '0;
        end else begin
            strobe_sync <= {strobe_sync[1:0], TX_SLOT_STROBE};
            bclk_sync <= {bclk_sync[1:0], MOD_BIT_CLOCK};
        end
    end

    assign strobe_rise = strobe_sync[1] && !strobe_sync[2];
    assign strobe_fall = !strobe_sync[1] && strobe_sync[2];
    assign sym_tick = bclk_sync[1] && !bclk_sync[2];

    // eighth symbol enable, realigned at each symbol edge
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            div_cnt <= '0;
            tick8 <= 1'b0;
        end else if (sym_tick || div_cnt == 8'(EIGHTH_DIV - 1)) begin
            div_cnt <= '0;
            tick8 <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick8 <= 1'b0;
        end
    end

    // ========================================
    // data path buffer
    tmg_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(CLOCK),
        .resetn(RESETN),
        .in_valid(TX_DATA_VALID),
        .in_data(TX_DATA),
        .in_ready(fifo_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(pop)
    );

    // ready toward the source, straight from a flop
    assign TX_DATA_READY = fifo_ready;

    // ========================================
    // slot timing
    // the start delay is skipped when another party clocks serial data
    assign start_load = (ctrl.serial_mode && !ctrl.bitclk_is_output) ? '0
        : dly.burst_start_delay;

    // state and delay counter
    always_ff @(posedge CLOCK) begin
        if (!RESETN || !ctrl.enable) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else begin
            if (tick8 && cnt != '0) begin
                cnt <= cnt - 1'b1;
            end
            unique case (state)
                ST_IDLE: if (strobe_rise) begin
                    state <= ST_START;
                    cnt <= start_load;
                end
                ST_START: if (cnt == '0) begin
                    state <= ST_FLOW;
                end
                ST_FLOW: if (strobe_fall) begin
                    if (!ctrl.gprs_mode) begin
                        state <= ST_IDLE;
                    end else if (ctrl.ramp_align_mode) begin
                        state <= ST_HOLD;
                    end else begin
                        state <= ST_DRAIN;
                    end
                end
                ST_DRAIN: if (sym_tick) begin
                    state <= ST_GAP;
                    cnt <= dly.inter_slot_resume_delay;
                end
                ST_HOLD: if (strobe_rise) begin
                    state <= ST_GAP;
                    cnt <= dly.inter_slot_resume_delay;
                end
                ST_GAP: if (cnt == '0) begin
                    state <= ST_FLOW;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ========================================
    // modulator feed: one bit per symbol edge, fifo only while flowing
    assign pop = fifo_valid && state == ST_FLOW && sym_tick;

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            MOD_DATA <= 1'b0;
            MOD_DATA_ACTIVE <= 1'b0;
        end else if (sym_tick) begin
            MOD_DATA <= pop ? fifo_data : ctrl.idle_fill_bit;
            MOD_DATA_ACTIVE <= pop;
        end
    end

    // ========================================
    // checks
    a_fill_when_idle: assert property (@(posedge CLOCK) disable iff (!RESETN)
        sym_tick && !pop |=> MOD_DATA == $past(ctrl.idle_fill_bit) && !MOD_DATA_ACTIVE)
        else $error("idle fill not presented");
    a_data_only_flow: assert property (@(posedge CLOCK) disable iff (!RESETN)
        pop |-> state == ST_FLOW)
        else $error("data taken outside flow");
    a_drain_no_data: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state == ST_FLOW && strobe_fall && ctrl.gprs_mode && !ctrl.ramp_align_mode
        && ctrl.enable |=> state == ST_DRAIN && !pop)
        else $error("fall did not stop data");
    a_gap_from_symbol: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state == ST_DRAIN && sym_tick && ctrl.enable
        |=> state == ST_GAP && cnt == $past(dly.inter_slot_resume_delay))
        else $error("gap delay not started at symbol end");
    a_hold_until_rise: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state == ST_HOLD && !strobe_rise && ctrl.enable |=> state == ST_HOLD)
        else $error("hold left without rise");
    a_start_load: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state == ST_IDLE && strobe_rise && ctrl.enable && !ctrl.serial_mode
        |=> state == ST_START && cnt == $past(dly.burst_start_delay))
        else $error("burst start delay not loaded");
    a_serial_skip: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state == ST_IDLE && strobe_rise && ctrl.enable && ctrl.serial_mode
        && !ctrl.bitclk_is_output |=> cnt == '0 ##1 state == ST_FLOW)
        else $error("start delay not skipped");
    a_count_step: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (state == ST_START || state == ST_GAP) && tick8 && cnt != '0 && ctrl.enable
        |=> cnt == $past(cnt) - 1'b1)
        else $error("delay counter did not step");
endmodule

// File: verif/tb_top.sv
// self-checking bench for the transmit modulator data gate
`timescale 1ns/1ps
// ==========
// bench
module tb_top
    import tmg_pkg::*;
;
    typedef struct {
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } tmg_row_s;
    logic clock;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata, rd;
    logic pready, pslverr, strobe, bclk, dvalid, dbit, dready, mdata, mactive, er;
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    tmg_row_s rows[7] = '{
        '{1'b0, REG_DELAYS_ADDR, 32'h0, 32'h0, 1'b0},
        '{1'b0, REG_CONTROL_ADDR, 32'h0, 32'h0, 1'b0},
        '{1'b1, REG_DELAYS_ADDR, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{1'b0, REG_DELAYS_ADDR, 32'h0, 32'h0003_FFFF, 1'b0},
        '{1'b1, REG_CONTROL_ADDR, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{1'b0, REG_CONTROL_ADDR, 32'h0, 32'h0000_003F, 1'b0},
        '{1'b0, 12'h100, 32'h0, 32'h0, 1'b1}};
    // system clock
    always #4 clock = ~clock;
    // design and partner
    tmg_gate u_dut (.CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TX_SLOT_STROBE(strobe), .MOD_BIT_CLOCK(bclk),
        .TX_DATA_VALID(dvalid), .TX_DATA(dbit), .TX_DATA_READY(dready), .MOD_DATA(mdata),
        .MOD_DATA_ACTIVE(mactive));
    tmg_baseband u_bb (.clock(clock), .slot_strobe(strobe), .bit_clock(bclk),
        .data_valid(dvalid), .data(dbit), .data_ready(dready));
    // ==========
    // tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // count cycles until the active flag reaches lvl; idle output must be the fill bit
    task automatic wait_act(input logic lvl, input int lim);
        n = 0;
        while (mactive !== lvl) begin
            if (mactive === 1'b0 && n >= 16) chk("idle fill", 32'(mdata), 32'h1);
            @(posedge clock);
            n++;
            if (n > lim) begin
                n_errors++;
                summarize();
            end
        end
    endtask
    task automatic prep(input logic [31:0] ctrl, input logic [31:0] dly);
        u_bb.set_strobe(1'b0);
        apb(1'b1, REG_CONTROL_ADDR, 32'h0);
        apb(1'b1, REG_DELAYS_ADDR, dly);
        apb(1'b1, REG_CONTROL_ADDR, ctrl);
        repeat (24) @(posedge clock);
    endtask
    // flowing slot, then strobe falls and the flag must drop
    task automatic slot_then_fall();
        u_bb.push(8'hC5);
        u_bb.set_strobe(1'b1);
        wait_act(1'b1, 100);
        repeat (16) @(posedge clock);
        u_bb.set_strobe(1'b0);
        wait_act(1'b0, 40);
        chk("stop after symbol", 32'(n <= 20), 32'h1);
    endtask
    // ==========
    // main sequence
    initial begin
        clock = 1'b0;
        resetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0000_0000;
        repeat (5) @(posedge clock);
        chk("ready in reset", 32'(pready), 32'h0);
        chk("active in reset", 32'(mactive), 32'h0);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        chk("fifo ready", 32'(dready), 32'h1);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            if (!rows[i].wr) chk("read data", rd, rows[i].rdata);
            chk("slave error", 32'(er), 32'(rows[i].err));
        end
        // burst start delay of 100 eighths, fifo filled until refused
        prep(32'h21, 32'h0000_0064);
        u_bb.push(8'hB2);
        u_bb.push(8'h66);
        repeat (20) @(posedge clock);
        chk("fifo full", 32'(dready), 32'h0);
        u_bb.set_strobe(1'b1);
        wait_act(1'b1, 300);
        chk("start delay", 32'(n >= 100 && n <= 124), 32'h1);
        repeat (3) @(posedge clock);
        for (int i = 7; i >= 0; i--) begin
            chk("data order", 32'(mdata), 32'(u_dut_exp(i)));
            repeat (8) @(posedge clock);
        end
        wait_act(1'b0, 200);
        // serial mode: delay only with the bit clock as output
        for (int i = 0; i < 2; i++) begin
            prep(32'h25 | (i << 3), 32'h0000_0064);
            u_bb.push(8'h3C);
            u_bb.set_strobe(1'b1);
            wait_act(1'b1, 300);
            chk("serial delay", 32'(n >= 100 && n <= 124), 32'(i));
            wait_act(1'b0, 200);
        end
        // gprs gap with ramp align off: count starts at symbol end
        prep(32'h23, 32'h0000_5000);
        slot_then_fall();
        wait_act(1'b1, 200);
        chk("gap delay", 32'(n >= 38 && n <= 49), 32'h1);
        // gprs gap with ramp align on: hold until rise, then delay
        prep(32'h33, 32'h0000_5000);
        slot_then_fall();
        repeat (100) begin
            @(posedge clock);
            chk("hold low", 32'(mactive), 32'h0);
        end
        u_bb.set_strobe(1'b1);
        wait_act(1'b1, 200);
        chk("resume delay", 32'(n >= 40 && n <= 56), 32'h1);
        // mid-run reset while a slot flows: outputs and registers clear
        resetn <= 1'b0;
        repeat (5) @(posedge clock);
        chk("active in second reset", 32'(mactive), 32'h0);
        chk("ready in second reset", 32'(dready), 32'h0);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        chk("fifo ready again", 32'(dready), 32'h1);
        apb(1'b0, REG_DELAYS_ADDR, 32'h0000_0000);
        chk("delays after reset", rd, 32'h0000_0000);
        apb(1'b0, REG_CONTROL_ADDR, 32'h0000_0000);
        chk("control after reset", rd, 32'h0000_0000);
        summarize();
    end
    // expected bit of the first byte, top bit first
    function automatic logic u_dut_exp(input int i);
        logic [7:0] b;
        b = 8'hB2;
        return b[i];
    endfunction
endmodule

// File: verif/tmg_baseband.sv
// baseband partner model: slot strobe, symbol clock and transmit bit stream
`timescale 1ns/1ps
// ==========
// baseband
module tmg_baseband (
    // clock
    input wire logic clock,
    // link pins
    output logic slot_strobe,
    output logic bit_clock,
    // bit stream
    output logic data_valid,
    output logic data,
    input wire logic data_ready
);
    logic q[$];
    // free running symbol clock, phase unrelated to the system clock
    initial begin
        slot_strobe = 1'b0;
        bit_clock = 1'b0;
        data_valid = 1'b0;
        data = 1'b0;
        #13;
        forever #32 bit_clock = ~bit_clock;
    end
    // offer queued bits; an idle line toggles its data bit on every clock
    always @(posedge clock) begin
        if (data_valid && data_ready)
            void'(q.pop_front());
        data_valid <= (q.size() != 0);
        data <= (q.size() != 0) ? q[0] : ~data;
    end
    // queue one byte, top bit goes out first
    task automatic push(input logic [7:0] bits);
        for (int i = 7; i >= 0; i--)
            q.push_back(bits[i]);
    endtask
    // move the strobe just after a clock edge
    task automatic set_strobe(input logic v);
        slot_strobe <= v;
    endtask
endmodule
